/* irq_host_model.sv */
`timescale 1ns/1ps
module irq_host_model (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic       int_i,
  input  wire logic       pol_i,
  output logic      [7:0] edges_o
);
  logic prev_ff;

  // Processor input counts each entry into the active level
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_ff <= 1'b0;
      edges_o <= 8'h00;
    end else begin
      prev_ff <= (int_i == pol_i);
      if ((int_i == pol_i) && !prev_ff) begin
        edges_o <= edges_o + 8'h01;
      end
    end
  end
endmodule : irq_host_model

/* irq_pin_shaper.sv */
`timescale 1ns/1ps
module irq_pin_shaper (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic assert_i,
  input  wire logic pulse_mode_i,
  input  wire logic polarity_i,
  output logic      irq_pin_o
);

  typedef struct packed {
    logic                        prev;
    logic [usb_irq_pkg::CNT_W-1:0] cnt;
    logic                        pin;
  } shaper_t;

  localparam logic [usb_irq_pkg::CNT_W-1:0] PULSE_LOAD =
    usb_irq_pkg::CNT_W'(usb_irq_pkg::IRQ_PULSE_CYC - 1);
  localparam logic [usb_irq_pkg::CNT_W-1:0] CNT_ONE = 4'h1;

  shaper_t q_ff;
  shaper_t nxt_q;

  always_comb begin
    logic trigger;
    logic active;
    trigger = 1'b0;
    active  = 1'b0;
    nxt_q = q_ff;
    nxt_q.prev = assert_i;
    trigger = assert_i & ~q_ff.prev;
    if (pulse_mode_i) begin
      // Fixed width counted in core clocks
      if (trigger) begin
        nxt_q.cnt = PULSE_LOAD;
      end else if (q_ff.cnt != '0) begin
        nxt_q.cnt = q_ff.cnt - CNT_ONE;
      end
      active = trigger | (q_ff.cnt != '0);
    end else begin
      nxt_q.cnt = '0;
      active = assert_i;
    end
    nxt_q.pin = polarity_i ? active : ~active;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_ff     <= '0;
      q_ff.pin <= usb_irq_pkg::PIN_IDLE_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign irq_pin_o = q_ff.pin;

endmodule : irq_pin_shaper

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic        mclk_i;
  logic        rst_n_i;
  logic [7:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        wait_rq;
  logic [7:0]  usb_ev;
  logic [7:0]  dma_ev;
  logic [5:0]  hs;
  logic        susp;
  logic        vbus;
  logic        wake;
  logic        irq;
  logic        pol;
  logic [7:0]  edges;
  logic [7:0]  e0;
  logic [31:0] tmp;
  logic [31:0] rd_q[$];
  int          err_count;
  int          checks;
  int          seed;
  int          m;

  usb_periph_irq_output i_dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_rq), .usb_event_i(usb_ev),
    .dma_event_i(dma_ev), .ctrl_ack_i(hs[0]), .ctrl_nak_i(hs[1]), .in_ack_i(hs[2]),
    .in_nak_i(hs[3]), .out_ack_i(hs[4]), .out_nak_i(hs[5]), .suspend_i(susp),
    .vbus_sense_i(vbus), .clk_wake_o(wake), .int_o(irq)
  );

  irq_host_model i_host (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .int_i(irq), .pol_i(pol), .edges_o(edges)
  );

  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task chk_int(input logic e);
    chk("int_o", {31'h0, irq}, {31'h0, e});
  endtask : chk_int

  task wrap_up;
    if (err_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  // Waitrequest settled mid-cycle stands through the next rising edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ws;
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    be <= 4'hF;
    wr <= w;
    rd <= !w;
    do begin
      @(negedge mclk_i);
      ws = wait_rq;
      @(posedge mclk_i);
    end while (ws !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    bus(1'b0, a, $random(seed));
  endtask : rd_chk

  task ev(input logic [7:0] u, input logic [7:0] d, input logic [5:0] h);
    @(posedge mclk_i);
    usb_ev <= u;
    dma_ev <= d;
    hs <= h;
    @(posedge mclk_i);
    usb_ev <= 8'h00;
    dma_ev <= 8'h00;
    hs <= 6'h00;
  endtask : ev

  // Ends mid-cycle so outputs are looked at once settled
  task idle(input int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : idle

  // Read data stands in the cycle where waitrequest is low
  always @(negedge mclk_i) begin
    if (rd && wait_rq === 1'b0) begin
      chk("readdata", rdata, rd_q.pop_front());
    end
  end

  initial begin
    #(100 * 20000);
    err_count++;
    wrap_up();
  end

  initial begin
    seed = 20009;
    rst_n_i = 1'b0;
    addr = 8'h00;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    be = 4'h0;
    usb_ev = 8'h00;
    dma_ev = 8'h00;
    hs = 6'h00;
    susp = 1'b0;
    vbus = 1'b0;
    pol = 1'b0;
    err_count = 0;
    checks = 0;
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    idle(1);
    chk_int(1'b1);
    rd_chk(usb_irq_pkg::MODE_OFS, 32'h0);
    rd_chk(usb_irq_pkg::CFG_OFS, 32'h0);
    bus(1'b1, 8'h40, $random(seed));
    rd_chk(8'h40, 32'h0);
    tmp = 32'h1 << ($unsigned($random(seed)) % 8);
    ev(tmp[7:0], 8'h00, 6'h00);
    idle(4);
    chk_int(1'b1);
    bus(1'b1, usb_irq_pkg::USB_EN_OFS, tmp);
    idle(4);
    chk_int(1'b1);
    bus(1'b1, usb_irq_pkg::MODE_OFS, 32'h1);
    idle(3);
    chk_int(1'b0);
    bus(1'b1, usb_irq_pkg::MODE_OFS, 32'h0);
    idle(3);
    chk_int(1'b0);
    rd_chk(usb_irq_pkg::USB_ST_OFS, tmp);
    idle(3);
    chk_int(1'b1);
    rd_chk(usb_irq_pkg::USB_ST_OFS, 32'h0);
    bus(1'b1, usb_irq_pkg::MODE_OFS, 32'h1);
    bus(1'b1, usb_irq_pkg::DMA_EN_OFS, 32'h4);
    ev(8'h00, 8'h20, 6'h00);
    idle(4);
    chk_int(1'b1);
    ev(8'h00, 8'h04, 6'h00);
    idle(4);
    chk_int(1'b0);
    bus(1'b1, usb_irq_pkg::DMA_ST_OFS, 32'hFFFFFFFF);
    idle(3);
    chk_int(1'b1);
    rd_chk(usb_irq_pkg::DMA_ST_OFS, 32'h0);
    bus(1'b1, usb_irq_pkg::USB_EN_OFS, 32'h0);
    // Same mode code in all three pipe fields
    for (m = 0; m < 4; m++) begin
      bus(1'b1, usb_irq_pkg::CFG_OFS, 32'(m) * 32'h54);
      ev(8'h00, 8'h00, 6'h15);
      idle(2);
      rd_chk(usb_irq_pkg::USB_ST_OFS, (m != 2) ? 32'h700 : 32'h0);
      ev(8'h00, 8'h00, 6'h2A);
      idle(2);
      rd_chk(usb_irq_pkg::USB_ST_OFS, (m == 1 || m == 2) ? 32'h700 : 32'h0);
    end
    bus(1'b1, usb_irq_pkg::CFG_OFS, 32'h3);
    pol <= 1'b1;
    bus(1'b1, usb_irq_pkg::USB_EN_OFS, 32'hFF);
    idle(4);
    e0 = edges;
    chk_int(1'b0);
    ev(8'h81, 8'h00, 6'h00);
    idle(6);
    chk("pulses", {24'h0, edges - e0}, 32'h1);
    chk_int(1'b0);
    rd_chk(usb_irq_pkg::USB_ST_OFS, 32'h81);
    bus(1'b1, usb_irq_pkg::CFG_OFS, 32'h2);
    ev(8'h02, 8'h00, 6'h00);
    idle(4);
    chk_int(1'b1);
    rd_chk(usb_irq_pkg::USB_ST_OFS, 32'h2);
    idle(3);
    chk_int(1'b0);
    bus(1'b1, usb_irq_pkg::CFG_OFS, 32'h1);
    pol <= 1'b0;
    idle(4);
    e0 = edges;
    chk_int(1'b1);
    ev(8'h04, 8'h00, 6'h00);
    idle(6);
    chk("pulses", {24'h0, edges - e0}, 32'h1);
    chk_int(1'b1);
    rd_chk(usb_irq_pkg::USB_ST_OFS, 32'h4);
    bus(1'b1, usb_irq_pkg::MODE_OFS, 32'h3);
    susp <= 1'b1;
    vbus <= 1'b1;
    idle(8);
    chk("clk_wake_o", {31'h0, wake}, 32'h0);
    bus(1'b1, usb_irq_pkg::MODE_OFS, 32'h1);
    vbus <= 1'b0;
    idle(8);
    chk("clk_wake_o", {31'h0, wake}, 32'h1);
    @(posedge mclk_i);
    susp <= 1'b0;
    idle(3);
    chk("clk_wake_o", {31'h0, wake}, 32'h0);
    wrap_up();
  end
endmodule : tb_top

/* usb_irq_pkg.sv */
package usb_irq_pkg;

  // Register byte offsets
  localparam logic [7:0] MODE_OFS   = 8'h0C;
  localparam logic [7:0] CFG_OFS    = 8'h10;
  localparam logic [7:0] USB_EN_OFS = 8'h14;
  localparam logic [7:0] USB_ST_OFS = 8'h18;
  localparam logic [7:0] DMA_EN_OFS = 8'h1C;
  localparam logic [7:0] DMA_ST_OFS = 8'h20;

  // Register widths
  localparam int MODE_W = 16;
  localparam int CFG_W  = 8;
  localparam int USB_W  = 16;
  localparam int DMA_W  = 8;
  localparam int EV_W   = 8;

  // Mode register fields
  localparam int MODE_GLOBAL_EN_BIT = 0;
  localparam int MODE_CLK_AON_BIT   = 1;
  localparam logic [MODE_W-1:0] MODE_RST = 16'h0000;

  // Interrupt configuration fields
  localparam int CFG_PULSE_BIT = 0;
  localparam int CFG_POL_BIT   = 1;
  localparam int CFG_CTRL_LSB  = 2;
  localparam int CFG_IN_LSB    = 4;
  localparam int CFG_OUT_LSB   = 6;
  localparam logic [CFG_W-1:0] CFG_RST = 8'h00;

  // Pipe status bits in the USB status register
  localparam int ST_CTRL_BIT = 8;
  localparam int ST_IN_BIT   = 9;
  localparam int ST_OUT_BIT  = 10;

  // Pipe interrupt mode codes
  localparam logic [1:0] PIPE_ACK_ONLY = 2'h0;
  localparam logic [1:0] PIPE_ACK_NAK  = 2'h1;
  localparam logic [1:0] PIPE_NAK_ONLY = 2'h2;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int IRQ_PULSE_NS  = 60;
  localparam int IRQ_PULSE_RAW = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IRQ_PULSE_CYC = (IRQ_PULSE_RAW < 1) ? 1 : IRQ_PULSE_RAW;
  localparam int CNT_W         = 4;

  localparam logic PIN_IDLE_RST = 1'b1;

endpackage : usb_irq_pkg

/* usb_periph_irq_output.sv */
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
// Summary of operation
// - Software sets the interrupt pin polarity and level-or-pulse signalling in the config register.
// - The pin is only newly asserted while the global enable bit of the mode register is set.
// - After reset the pin is active low and level signalled.
// - In pulse mode one fixed pulse follows each rise of the combined pending interrupt.
// - Each USB event sets its own USB status bit and each DMA event its own DMA reason bit.
// - An event reaches the pin only when its enable bit is set.
// - Three two-bit fields select which handshakes of the control, IN and OUT pipes interrupt.
// - An event with the global enable clear still sets its status bit but not the pin.
// - In level mode setting the global enable with status pending asserts the pin at once.
// - In level mode clearing the global enable does not drop an asserted pin while pending.
// - In level mode the pin drops only once software has cleared all pending status.
// - Suspended with clock-always-on clear, bus supply activity requests a clock wake-up.
module usb_periph_irq_output (
  input  wire logic                          mclk_i,
  input  wire logic                          rst_n_i,
  input  wire logic [7:0]                    avs_address_i,
  input  wire logic                          avs_read_i,
  input  wire logic                          avs_write_i,
  input  wire logic [31:0]                   avs_writedata_i,
  input  wire logic [3:0]                    avs_byteenable_i,
  output logic      [31:0]                   avs_readdata_o,
  output logic                               avs_waitrequest_o,
  input  wire logic [usb_irq_pkg::EV_W-1:0]  usb_event_i,
  input  wire logic [usb_irq_pkg::DMA_W-1:0] dma_event_i,
  input  wire logic                          ctrl_ack_i,
  input  wire logic                          ctrl_nak_i,
  input  wire logic                          in_ack_i,
  input  wire logic                          in_nak_i,
  input  wire logic                          out_ack_i,
  input  wire logic                          out_nak_i,
  input  wire logic                          suspend_i,
  input  wire logic                          vbus_sense_i,
  output logic                               clk_wake_o,
  output logic                               int_o
);

  typedef struct packed {
    logic [usb_irq_pkg::MODE_W-1:0] mode;
    logic [usb_irq_pkg::CFG_W-1:0]  cfg;
    logic [usb_irq_pkg::USB_W-1:0]  usb_en;
    logic [usb_irq_pkg::USB_W-1:0]  usb_st;
    logic [usb_irq_pkg::DMA_W-1:0]  dma_en;
    logic [usb_irq_pkg::DMA_W-1:0]  dma_st;
    logic                           ack;
    logic [31:0]                    rdata;
    logic                           irq_on;
    logic                           sync1;
    logic                           sync2;
    logic                           sync3;
    logic                           vbus_stable;
    logic                           wake;
  } core_t;

  core_t q_ff;
  core_t nxt_q;

  logic pending;
  logic vbus_change;
  logic global_en;
  logic clk_aon;
  logic pulse_mode;
  logic polarity;
  logic ctrl_hit;
  logic in_hit;
  logic out_hit;

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : be_mask

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] wdata,
                                           input logic [3:0]  be);
    logic [31:0] m;
    m = be_mask(be);
    return (old_v & ~m) | (wdata & m);
  endfunction : be_merge

  function automatic logic pipe_hit(input logic [1:0] mode_v,
                                    input logic       ack_v,
                                    input logic       nak_v);
    case (mode_v)
      usb_irq_pkg::PIPE_ACK_NAK:  return ack_v | nak_v;
      usb_irq_pkg::PIPE_NAK_ONLY: return nak_v;
      default:                    return ack_v;
    endcase
  endfunction : pipe_hit

  assign global_en  = q_ff.mode[usb_irq_pkg::MODE_GLOBAL_EN_BIT];
  assign clk_aon    = q_ff.mode[usb_irq_pkg::MODE_CLK_AON_BIT];
  assign pulse_mode = q_ff.cfg[usb_irq_pkg::CFG_PULSE_BIT];
  assign polarity   = q_ff.cfg[usb_irq_pkg::CFG_POL_BIT];

  // Per-pipe handshake selection
  assign ctrl_hit = pipe_hit(q_ff.cfg[usb_irq_pkg::CFG_CTRL_LSB +: 2],
                             ctrl_ack_i, ctrl_nak_i);
  assign in_hit   = pipe_hit(q_ff.cfg[usb_irq_pkg::CFG_IN_LSB +: 2],
                             in_ack_i, in_nak_i);
  assign out_hit  = pipe_hit(q_ff.cfg[usb_irq_pkg::CFG_OUT_LSB +: 2],
                             out_ack_i, out_nak_i);

  assign pending = (|(q_ff.usb_st & q_ff.usb_en)) | (|(q_ff.dma_st & q_ff.dma_en));

  // Second and third stage must agree before a change counts
  assign vbus_change = (q_ff.sync2 == q_ff.sync3) && (q_ff.sync3 != q_ff.vbus_stable);

  always_comb begin
    logic                          req;
    logic                          do_wr;
    logic                          do_rd;
    logic [31:0]                   wclr;
    logic [usb_irq_pkg::USB_W-1:0] usb_set;
    logic [usb_irq_pkg::USB_W-1:0] usb_clr;
    logic [usb_irq_pkg::DMA_W-1:0] dma_clr;
    logic [31:0]                   rmux;
    logic [31:0]                   merged;
    req     = 1'b0;
    do_wr   = 1'b0;
    do_rd   = 1'b0;
    wclr    = '0;
    usb_set = '0;
    usb_clr = '0;
    dma_clr = '0;
    rmux    = '0;
    merged  = '0;
    nxt_q   = q_ff;

    // Bus slave: one wait state, access completes while ack is high
    req       = avs_read_i | avs_write_i;
    nxt_q.ack = req & ~q_ff.ack;
    do_wr     = avs_write_i & q_ff.ack;
    do_rd     = avs_read_i & q_ff.ack;
    wclr      = avs_writedata_i & be_mask(avs_byteenable_i);

    case (avs_address_i)
      usb_irq_pkg::MODE_OFS:   rmux = 32'(q_ff.mode);
      usb_irq_pkg::CFG_OFS:    rmux = 32'(q_ff.cfg);
      usb_irq_pkg::USB_EN_OFS: rmux = 32'(q_ff.usb_en);
      usb_irq_pkg::USB_ST_OFS: rmux = 32'(q_ff.usb_st);
      usb_irq_pkg::DMA_EN_OFS: rmux = 32'(q_ff.dma_en);
      usb_irq_pkg::DMA_ST_OFS: rmux = 32'(q_ff.dma_st);
      default:                 rmux = '0;
    endcase
    if (avs_read_i && !q_ff.ack) begin
      nxt_q.rdata = rmux;
    end

    if (do_wr) begin
      case (avs_address_i)
        usb_irq_pkg::MODE_OFS: begin
          merged = be_merge(32'(q_ff.mode), avs_writedata_i, avs_byteenable_i);
          nxt_q.mode = merged[usb_irq_pkg::MODE_W-1:0];
        end
        usb_irq_pkg::CFG_OFS: begin
          merged = be_merge(32'(q_ff.cfg), avs_writedata_i, avs_byteenable_i);
          nxt_q.cfg = merged[usb_irq_pkg::CFG_W-1:0];
        end
        usb_irq_pkg::USB_EN_OFS: begin
          merged = be_merge(32'(q_ff.usb_en), avs_writedata_i, avs_byteenable_i);
          nxt_q.usb_en = merged[usb_irq_pkg::USB_W-1:0];
        end
        usb_irq_pkg::USB_ST_OFS: begin
          usb_clr = wclr[usb_irq_pkg::USB_W-1:0];
        end
        usb_irq_pkg::DMA_EN_OFS: begin
          merged = be_merge(32'(q_ff.dma_en), avs_writedata_i, avs_byteenable_i);
          nxt_q.dma_en = merged[usb_irq_pkg::DMA_W-1:0];
        end
        usb_irq_pkg::DMA_ST_OFS: begin
          dma_clr = wclr[usb_irq_pkg::DMA_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Read clears only the bits that were reported
    if (do_rd && avs_address_i == usb_irq_pkg::USB_ST_OFS) begin
      usb_clr = usb_clr | q_ff.rdata[usb_irq_pkg::USB_W-1:0];
    end
    if (do_rd && avs_address_i == usb_irq_pkg::DMA_ST_OFS) begin
      dma_clr = dma_clr | q_ff.rdata[usb_irq_pkg::DMA_W-1:0];
    end

    usb_set = '0;
    usb_set[usb_irq_pkg::EV_W-1:0]   = usb_event_i;
    usb_set[usb_irq_pkg::ST_CTRL_BIT] = ctrl_hit;
    usb_set[usb_irq_pkg::ST_IN_BIT]   = in_hit;
    usb_set[usb_irq_pkg::ST_OUT_BIT]  = out_hit;

    // Set wins over clear; global enable does not gate recording
    nxt_q.usb_st = (q_ff.usb_st & ~usb_clr) | usb_set;
    nxt_q.dma_st = (q_ff.dma_st & ~dma_clr) | dma_event_i;

    // Asserted irq_on holds through a global disable until pending clears
    nxt_q.irq_on = pending & (global_en | q_ff.irq_on);

    nxt_q.sync1 = vbus_sense_i;
    nxt_q.sync2 = q_ff.sync1;
    nxt_q.sync3 = q_ff.sync2;
    if (q_ff.sync2 == q_ff.sync3) begin
      nxt_q.vbus_stable = q_ff.sync3;
    end
    nxt_q.wake = suspend_i & ~clk_aon & (q_ff.wake | vbus_change);
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_ff      <= '0;
      q_ff.mode <= usb_irq_pkg::MODE_RST;
      q_ff.cfg  <= usb_irq_pkg::CFG_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  irq_pin_shaper u_shaper (
    .mclk_i       (mclk_i),
    .rst_n_i      (rst_n_i),
    .assert_i     (q_ff.irq_on),
    .pulse_mode_i (pulse_mode),
    .polarity_i   (polarity),
    .irq_pin_o    (int_o)
  );

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~q_ff.ack;
  assign avs_readdata_o    = q_ff.rdata;
  assign clk_wake_o        = q_ff.wake;

  property p_global_gate;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (!global_en && !q_ff.irq_on) |=> !q_ff.irq_on;
  endproperty
  a_global_gate: assert property (p_global_gate)
    else $error("irq asserted with global enable clear");

  property p_enable_now;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (global_en && pending && !pulse_mode && $stable(q_ff.cfg))
        |-> ##[1:2] (int_o == polarity);
  endproperty
  a_enable_now: assert property (p_enable_now)
    else $error("pin not active after enable with pending status");

  property p_hold_on_disable;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (q_ff.irq_on && pending) |=> q_ff.irq_on;
  endproperty
  a_hold_on_disable: assert property (p_hold_on_disable)
    else $error("irq dropped while status pending");

  property p_drop_when_clear;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (q_ff.irq_on && !pending) |=> !q_ff.irq_on;
  endproperty
  a_drop_when_clear: assert property (p_drop_when_clear)
    else $error("irq stayed on with nothing pending");

  property p_dma_record;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (|dma_event_i) |=> ((q_ff.dma_st & $past(dma_event_i)) == $past(dma_event_i));
  endproperty
  a_dma_record: assert property (p_dma_record)
    else $error("dma event not recorded");

  property p_masked_quiet;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (q_ff.usb_en == '0 && q_ff.dma_en == '0) |=> !q_ff.irq_on;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("irq on with all enables clear");

  property p_pulse_width;
    @(posedge mclk_i) disable iff (!rst_n_i)
      ($rose(q_ff.irq_on) && pulse_mode && $stable(q_ff.cfg))
        |=> (int_o == polarity) ##1 (int_o != polarity);
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("pulse width wrong");

  property p_level_polarity;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (!pulse_mode && q_ff.irq_on) |=> (int_o == $past(polarity));
  endproperty
  a_level_polarity: assert property (p_level_polarity)
    else $error("level pin polarity wrong");

  property p_reset_idle;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (q_ff.cfg == usb_irq_pkg::CFG_RST && !q_ff.irq_on) |=> int_o;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("default pin not idle high");

  property p_nak_only;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (q_ff.cfg[usb_irq_pkg::CFG_CTRL_LSB +: 2] == usb_irq_pkg::PIPE_NAK_ONLY
       && ctrl_ack_i && !ctrl_nak_i && !q_ff.usb_st[usb_irq_pkg::ST_CTRL_BIT])
        |=> !q_ff.usb_st[usb_irq_pkg::ST_CTRL_BIT];
  endproperty
  a_nak_only: assert property (p_nak_only)
    else $error("ack set control status in nak-only mode");

  property p_vbus_wake;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (suspend_i && !clk_aon && vbus_change) |=> clk_wake_o;
  endproperty
  a_vbus_wake: assert property (p_vbus_wake)
    else $error("no wake on supply activity");

  property p_wake_release;
    @(posedge mclk_i) disable iff (!rst_n_i)
      !suspend_i |=> !clk_wake_o;
  endproperty
  a_wake_release: assert property (p_wake_release)
    else $error("wake request held outside suspend");

  property p_usb_record;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (|usb_event_i) |=> ((q_ff.usb_st[usb_irq_pkg::EV_W-1:0] & $past(usb_event_i))
                          == $past(usb_event_i));
  endproperty
  a_usb_record: assert property (p_usb_record)
    else $error("usb event not recorded");

  property p_ack_only;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (q_ff.cfg[usb_irq_pkg::CFG_CTRL_LSB +: 2] == usb_irq_pkg::PIPE_ACK_ONLY && ctrl_ack_i)
        |=> q_ff.usb_st[usb_irq_pkg::ST_CTRL_BIT];
  endproperty
  a_ack_only: assert property (p_ack_only)
    else $error("ack missed in ack-only mode");

  property p_pulse_idle;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (pulse_mode && !q_ff.irq_on) |=> (int_o == !$past(polarity));
  endproperty
  a_pulse_idle: assert property (p_pulse_idle)
    else $error("pulse pin not at inactive level");

endmodule : usb_periph_irq_output
